// [csf_pkg.sv]
// csf_pkg: constants for the processor status flag register
// assumes: included before csf_top and csf_alu; nothing imported
package csf_pkg;
	// bit positions within the status byte
	localparam int BIT_IND_BANK  = 7;
	localparam int BIT_BANK_HI   = 6;
	localparam int BIT_BANK_LO   = 5;
	localparam int BIT_WDT_EXP   = 4;
	localparam int BIT_SLEEP_ENT = 3;
	localparam int BIT_NULL      = 2;
	localparam int BIT_NIBBLE    = 1;
	localparam int BIT_MSB       = 0;
	// reset value: bank bits clear, watchdog expiry and sleep entered set, flags clear
	localparam logic [7:0] STATUS_RESET = 8'h18;
	// register offsets on the plain software port
	localparam logic [3:0] OFF_STATUS   = 4'h0;
	localparam logic [3:0] OFF_IRQ_STAT = 4'h1;
	localparam logic [3:0] OFF_IRQ_CLR  = 4'h2;
	localparam logic [3:0] OFF_IRQ_EN   = 4'h3;
	// event bits in the interrupt registers
	localparam int EV_WDT_TIMEOUT = 0;
	localparam int EV_SLEEP       = 1;
	localparam int EV_NULL_RESULT = 2;
	localparam int EV_WIDTH       = 3;
	localparam logic [EV_WIDTH-1:0] IRQ_RESET = 3'h0;
	// alu operation codes
	typedef enum logic [2:0] {
		CSF_OP_NONE  = 3'b000,
		CSF_OP_ADD   = 3'b001,
		CSF_OP_SUB   = 3'b010,
		CSF_OP_RR    = 3'b011,
		CSF_OP_RL    = 3'b100,
		CSF_OP_LOGIC = 3'b101
	} csf_op_type;
	// direct bank base addresses
	localparam logic [8:0] BANK0_BASE = 9'h000;
	localparam logic [8:0] BANK1_BASE = 9'h080;
	localparam logic [8:0] BANK2_BASE = 9'h100;
	localparam logic [8:0] BANK3_BASE = 9'h180;
endpackage

// [csf_alu.sv]
// csf_alu: combinational result and flag generation for one operation
// assumes: operands valid in the cycle the op code is presented
`timescale 1ns/1ns
module csf_alu (
	input  wire csf_pkg::csf_op_type op,
	input  wire logic [7:0]         a_val,
	input  wire logic [7:0]         b_val,
	input  wire logic               carry_in,
	input  wire logic [7:0]         logic_res,
	output logic      [7:0]         result,
	output logic                    null_flag,
	output logic                    nibble_flag,
	output logic                    msb_flag,
	output logic                    upd_null,
	output logic                    upd_nibble,
	output logic                    upd_msb
);
	// subtraction is a + ~b + 1, so carries come out as active-low borrows
	wire logic [7:0] b_eff   = (op == csf_pkg::CSF_OP_SUB) ? ~b_val : b_val;
	wire logic       cin     = (op == csf_pkg::CSF_OP_SUB);
	wire logic [4:0] low_sum = {1'b0, a_val[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
	wire logic [8:0] sum     = {1'b0, a_val} + {1'b0, b_eff} + {8'h00, cin};
	wire logic       arith   = (op == csf_pkg::CSF_OP_ADD) || (op == csf_pkg::CSF_OP_SUB);
	wire logic       rot     = (op == csf_pkg::CSF_OP_RR) || (op == csf_pkg::CSF_OP_RL);

	// result select; rotates pass through the carry flag
	always_comb begin
		unique case (op)
			csf_pkg::CSF_OP_ADD,
			csf_pkg::CSF_OP_SUB:   result = sum[7:0];
			csf_pkg::CSF_OP_RR:    result = {carry_in, a_val[7:1]};
			csf_pkg::CSF_OP_RL:    result = {a_val[6:0], carry_in};
			csf_pkg::CSF_OP_LOGIC: result = logic_res;
			default:               result = a_val;
		endcase
	end

	// flag values and which of them this op updates
	assign null_flag   = (result == 8'h00);
	assign nibble_flag = low_sum[4];
	assign msb_flag    = rot ? ((op == csf_pkg::CSF_OP_RR) ? a_val[0] : a_val[7])
	                         : sum[8];
	assign upd_null    = arith || (op == csf_pkg::CSF_OP_LOGIC);
	assign upd_nibble  = arith;
	assign upd_msb     = arith || rot;
endmodule

// [csf_top.sv]
// csf_top: the processor status flag register with bank select and power flags
// assumes: core drives one op per cycle on clk; software port is single-cycle
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module csf_top (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire csf_pkg::csf_op_type     alu_op,
	input  wire logic [7:0]              alu_a,
	input  wire logic [7:0]              alu_b,
	input  wire logic [7:0]              alu_logic_res,
	input  wire logic                    dest_is_status,
	input  wire logic                    core_wr,
	input  wire logic [7:0]              core_wr_data,
	input  wire logic                    watchdog_kick_instr,
	input  wire logic                    sleep_instr,
	input  wire logic                    watchdog_timeout,
	input  wire logic [3:0]              sw_addr,
	input  wire logic [7:0]              sw_wdata,
	input  wire logic                    sw_wr,
	input  wire logic                    sw_rd,
	output logic      [7:0]              sw_rdata,
	output logic      [7:0]              alu_result,
	output logic      [7:0]              status_out,
	output logic      [1:0]              direct_bank_field,
	output logic                         indirect_bank_bit,
	output logic      [8:0]              direct_bank_base,
	output logic                         irq
);
	logic [7:0]                   status_flags_reg;
	logic [7:0]                   status_flags_next;
	logic [csf_pkg::EV_WIDTH-1:0] irq_stat_reg;
	logic [csf_pkg::EV_WIDTH-1:0] irq_stat_next;
	logic [csf_pkg::EV_WIDTH-1:0] irq_en_reg;
	logic [7:0]                   sw_rdata_reg;
	logic [7:0]                   result_reg;
	logic                         wdt_ext_s1_reg;
	logic                         wdt_ext_s2_reg;

	wire logic null_v;
	wire logic nibble_v;
	wire logic msb_v;
	wire logic upd_null;
	wire logic upd_nibble;
	wire logic upd_msb;
	wire logic [7:0] res_v;

	csf_alu csf_alu_i (
		.op          (alu_op),
		.a_val       (alu_a),
		.b_val       (alu_b),
		.carry_in    (status_flags_reg[csf_pkg::BIT_MSB]),
		.logic_res   (alu_logic_res),
		.result      (res_v),
		.null_flag   (null_v),
		.nibble_flag (nibble_v),
		.msb_flag    (msb_v),
		.upd_null    (upd_null),
		.upd_nibble  (upd_nibble),
		.upd_msb     (upd_msb)
	);

	// map a bank field to its base address; used only for the direct_bank_base output
	function automatic logic [8:0] bank_base(input logic [1:0] sel);
		unique case (sel)
			2'b00: bank_base = csf_pkg::BANK0_BASE;
			2'b01: bank_base = csf_pkg::BANK1_BASE;
			2'b10: bank_base = csf_pkg::BANK2_BASE;
			2'b11: bank_base = csf_pkg::BANK3_BASE;
		endcase
	endfunction

	// write decode: the core and software both reach the status byte
	wire logic       sw_wr_status = sw_wr && (sw_addr == csf_pkg::OFF_STATUS);
	wire logic       sw_wr_clr    = sw_wr && (sw_addr == csf_pkg::OFF_IRQ_CLR);
	wire logic       sw_wr_en     = sw_wr && (sw_addr == csf_pkg::OFF_IRQ_EN);
	wire logic       core_wr_st   = core_wr && dest_is_status;
	wire logic       any_wr       = core_wr_st || sw_wr_status;
	// core write has priority over a coincident software write
	wire logic [7:0] wr_val       = core_wr_st ? core_wr_data : sw_wdata;

	// timeout arrives from the watchdog's own timing, so it is synchronised
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wdt_ext_s1_reg <= 1'b0;
			wdt_ext_s2_reg <= 1'b0;
		end else begin
			wdt_ext_s1_reg <= watchdog_timeout;
			wdt_ext_s2_reg <= wdt_ext_s1_reg;
		end
	end

	// next status value; the alu flags win over written data in the same cycle
	always_comb begin
		status_flags_next = status_flags_reg;
		if (any_wr) begin
			status_flags_next[csf_pkg::BIT_IND_BANK] = wr_val[csf_pkg::BIT_IND_BANK];
			status_flags_next[csf_pkg::BIT_BANK_HI]  = wr_val[csf_pkg::BIT_BANK_HI];
			status_flags_next[csf_pkg::BIT_BANK_LO]  = wr_val[csf_pkg::BIT_BANK_LO];
			if (!upd_null)
				status_flags_next[csf_pkg::BIT_NULL] = wr_val[csf_pkg::BIT_NULL];
			if (!upd_nibble)
				status_flags_next[csf_pkg::BIT_NIBBLE] = wr_val[csf_pkg::BIT_NIBBLE];
			if (!upd_msb)
				status_flags_next[csf_pkg::BIT_MSB] = wr_val[csf_pkg::BIT_MSB];
		end
		// power flags take no written data at all
		if (upd_null)
			status_flags_next[csf_pkg::BIT_NULL] = null_v;
		if (upd_nibble)
			status_flags_next[csf_pkg::BIT_NIBBLE] = nibble_v;
		if (upd_msb)
			status_flags_next[csf_pkg::BIT_MSB] = msb_v;
		// kick and sleep mark the flags; timeout last so it is never masked
		if (watchdog_kick_instr) begin
			status_flags_next[csf_pkg::BIT_WDT_EXP]   = 1'b1;
			status_flags_next[csf_pkg::BIT_SLEEP_ENT] = 1'b1;
		end
		if (sleep_instr) begin
			status_flags_next[csf_pkg::BIT_WDT_EXP]   = 1'b1;
			status_flags_next[csf_pkg::BIT_SLEEP_ENT] = 1'b0;
		end
		if (wdt_ext_s2_reg)
			status_flags_next[csf_pkg::BIT_WDT_EXP] = 1'b0;
	end

	// sticky event bits; a new event wins over a clear in the same cycle
	wire logic [csf_pkg::EV_WIDTH-1:0] ev_vec = {upd_null && null_v, sleep_instr, wdt_ext_s2_reg};
	always_comb begin
		irq_stat_next = irq_stat_reg;
		if (sw_wr_clr)
			irq_stat_next = irq_stat_reg & ~sw_wdata[csf_pkg::EV_WIDTH-1:0];
		irq_stat_next = irq_stat_next | ev_vec;
	end

	// status register holds power-on state until released
	always_ff @(posedge clk) begin
		if (sys_rst)
			status_flags_reg <= csf_pkg::STATUS_RESET;
		else
			status_flags_reg <= status_flags_next;
	end

	// interrupt status and enable
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_stat_reg <= csf_pkg::IRQ_RESET;
			irq_en_reg   <= csf_pkg::IRQ_RESET;
		end else begin
			irq_stat_reg <= irq_stat_next;
			if (sw_wr_en)
				irq_en_reg <= sw_wdata[csf_pkg::EV_WIDTH-1:0];
		end
	end

	// read mux; unmapped and write-only offsets read as zero
	wire logic [7:0] rd_mux =
		(sw_addr == csf_pkg::OFF_STATUS)   ? status_flags_reg :
		(sw_addr == csf_pkg::OFF_IRQ_STAT) ? {5'h00, irq_stat_reg} :
		(sw_addr == csf_pkg::OFF_IRQ_EN)   ? {5'h00, irq_en_reg} :
		8'h00;

	// read data registered: valid only the cycle after the strobe
	always_ff @(posedge clk) begin
		if (sys_rst)
			sw_rdata_reg <= 8'h00;
		else
			sw_rdata_reg <= sw_rd ? rd_mux : 8'h00;
	end

	// alu result registered alongside the flags it produced
	always_ff @(posedge clk) begin
		if (sys_rst)
			result_reg <= 8'h00;
		else
			result_reg <= res_v;
	end

	// bank selection straight from the stored bits
	assign direct_bank_field = status_flags_reg[csf_pkg::BIT_BANK_HI:csf_pkg::BIT_BANK_LO];
	assign indirect_bank_bit = status_flags_reg[csf_pkg::BIT_IND_BANK];
	assign direct_bank_base  = bank_base(direct_bank_field);
	assign status_out        = status_flags_reg;
	assign sw_rdata          = sw_rdata_reg;
	assign alu_result        = result_reg;
	assign irq               = |(irq_stat_reg & irq_en_reg);
endmodule

// [csf_top_properties.sv]
// csf_top_properties: port-level checks of the status flag register
// assumes: bound to csf_top, single clock, synchronous active-high reset
`timescale 1ns/1ns
module csf_props (
	input wire logic                 clk,
	input wire logic                 sys_rst,
	input wire csf_pkg::csf_op_type  alu_op,
	input wire logic [7:0]           alu_a,
	input wire logic [7:0]           alu_b,
	input wire logic                 dest_is_status,
	input wire logic                 core_wr,
	input wire logic [7:0]           core_wr_data,
	input wire logic                 watchdog_kick_instr,
	input wire logic                 sleep_instr,
	input wire logic                 watchdog_timeout,
	input wire logic [3:0]           sw_addr,
	input wire logic [7:0]           sw_wdata,
	input wire logic                 sw_wr,
	input wire logic [7:0]           status_out,
	input wire logic [1:0]           direct_bank_field,
	input wire logic [8:0]           direct_bank_base
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// reference carries, worked out independently of the alu
	wire logic [4:0] nib_sum       = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
	wire logic [8:0] full_sum      = {1'b0, alu_a} + {1'b0, alu_b};
	wire logic       no_borrow     = alu_a >= alu_b;
	wire logic       nib_no_borrow = alu_a[3:0] >= alu_b[3:0];
	wire logic       core_st_wr    = core_wr && dest_is_status;
	wire logic       sw_st_wr      = sw_wr && (sw_addr == csf_pkg::OFF_STATUS);
	a_bank_field: assert property (direct_bank_field == status_out[6:5]) else $error("bank field off");
	a_bank_base: assert property (direct_bank_base == {status_out[6:5], 7'h00}) else $error("bank base off");
	a_core_bank: assert property (core_st_wr |=> status_out[7:5] == $past(core_wr_data[7:5]))
		else $error("core bank write lost");
	a_sw_bank: assert property (sw_st_wr && !core_st_wr |=> status_out[7:5] == $past(sw_wdata[7:5]))
		else $error("software bank write lost");
	a_add_null: assert property (alu_op == csf_pkg::CSF_OP_ADD && full_sum[7:0] == 8'h00 |=> status_out[2])
		else $error("null flag not set");
	a_add_nibble: assert property (alu_op == csf_pkg::CSF_OP_ADD |=> status_out[1] == $past(nib_sum[4]))
		else $error("nibble flag wrong");
	a_sub_nibble: assert property (alu_op == csf_pkg::CSF_OP_SUB |=> status_out[1] == $past(nib_no_borrow))
		else $error("nibble borrow wrong");
	a_add_carry: assert property (alu_op == csf_pkg::CSF_OP_ADD |=> status_out[0] == $past(full_sum[8]))
		else $error("carry flag wrong");
	a_sub_borrow: assert property (alu_op == csf_pkg::CSF_OP_SUB |=> status_out[0] == $past(no_borrow))
		else $error("borrow flag wrong");
	a_rot_right: assert property (alu_op == csf_pkg::CSF_OP_RR |=> status_out[0] == $past(alu_a[0]))
		else $error("rotate out bit wrong");
	a_rot_left: assert property (alu_op == csf_pkg::CSF_OP_RL |=> status_out[0] == $past(alu_a[7]))
		else $error("rotate left out bit wrong");
	// the timeout reaches the flags two edges after the pin is sampled, and it wins over kick and sleep
	a_sleep_flags: assert property (sleep_instr && !$past(watchdog_timeout, 2) |=> status_out[4:3] == 2'h2)
		else $error("sleep flags wrong");
	a_kick_flags: assert property (watchdog_kick_instr && !sleep_instr && !$past(watchdog_timeout, 2)
		|=> status_out[4:3] == 2'h3) else $error("kick flags wrong");
	a_timeout_clear: assert property ($past(watchdog_timeout, 2) && !$past(sys_rst) && !$past(sys_rst, 2)
		|=> !status_out[4]) else $error("timeout did not clear expiry flag");
	// no write of any kind may move the power flags
	a_power_hold: assert property (!watchdog_kick_instr && !sleep_instr && !$past(watchdog_timeout, 2)
		|=> status_out[4:3] == $past(status_out[4:3])) else $error("power flags moved by a write");
	// main scenarios reached
	cover property (alu_op == csf_pkg::CSF_OP_SUB);
	cover property (alu_op == csf_pkg::CSF_OP_RL);
	cover property (sleep_instr);
	cover property (watchdog_kick_instr);
	cover property (watchdog_timeout);
endmodule
bind csf_top csf_props csf_props_i (.clk(clk), .sys_rst(sys_rst), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
	.dest_is_status(dest_is_status), .core_wr(core_wr), .core_wr_data(core_wr_data),
	.watchdog_kick_instr(watchdog_kick_instr), .sleep_instr(sleep_instr), .watchdog_timeout(watchdog_timeout),
	.sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .status_out(status_out),
	.direct_bank_field(direct_bank_field), .direct_bank_base(direct_bank_base));

// [csf_top_test.sv]
// csf_top_test: directed self-checking bench for the status flag register
// assumes: csf_pkg and csf_top compiled first; watchdog timeout has 2 sync stages
`timescale 1ns/1ns
module csf_top_test;
	logic                clk = 1'h0, sys_rst = 1'h1, dest_is_status = 1'h0, core_wr = 1'h0, sw_wr = 1'h0;
	logic                watchdog_kick_instr = 1'h0, sleep_instr = 1'h0, watchdog_timeout = 1'h0, sw_rd = 1'h0;
	csf_pkg::csf_op_type alu_op = csf_pkg::CSF_OP_NONE;
	logic [7:0]          alu_a = 8'h00, alu_b = 8'h00, alu_logic_res = 8'h00, core_wr_data = 8'h00, sw_wdata = 8'h00;
	logic [3:0]          sw_addr = 4'h0;
	logic [7:0]          sw_rdata, alu_result, status_out, rd;
	logic [1:0]          direct_bank_field;
	logic [8:0]          direct_bank_base;
	logic                indirect_bank_bit, irq;
	int                  miscompares = 0, checked = 0, cycles = 0;
	csf_top csf_top_i (.clk(clk), .sys_rst(sys_rst), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
		.alu_logic_res(alu_logic_res), .dest_is_status(dest_is_status), .core_wr(core_wr),
		.core_wr_data(core_wr_data), .watchdog_kick_instr(watchdog_kick_instr), .sleep_instr(sleep_instr),
		.watchdog_timeout(watchdog_timeout), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
		.sw_rdata(sw_rdata), .alu_result(alu_result), .status_out(status_out), .direct_bank_field(direct_bank_field),
		.indirect_bank_bit(indirect_bank_bit), .direct_bank_base(direct_bank_base), .irq(irq));
	// 4 ns clock; cycle ceiling of 1000 far above the roughly 75 cycles the tests need
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// software port: one-cycle strobes, read data only in the following cycle
	task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'h1;
		@(posedge clk);
		sw_wr <= 1'h0;
		#1;
	endtask
	task automatic sw_read(input logic [3:0] a);
		@(posedge clk);
		sw_addr <= a;
		sw_rd <= 1'h1;
		@(posedge clk);
		sw_rd <= 1'h0;
		#1 rd = sw_rdata;
	endtask
	task automatic t_reset();
		sw_read(csf_pkg::OFF_STATUS);
		check(rd, 8'h18);
		check(irq, 1'h0);
	endtask
	// every bank code; watchdog and sleep bits written as zero must hold
	task automatic t_banks();
		for (int i = 0; i < 8; i++) begin
			sw_write(csf_pkg::OFF_STATUS, {i[2:0], 5'h07});
			check(status_out, {i[2:0], 5'h1f});
			check(direct_bank_field, i[1:0]);
			check(direct_bank_base, {i[1:0], 7'h00});
			check(indirect_bank_bit, i[2]);
		end
	endtask
	// add, subtract, rotates and logic; rotates carry in the previous msb flag
	task automatic t_alu();
		csf_pkg::csf_op_type ops[7] = '{csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_SUB,
			csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_RR, csf_pkg::CSF_OP_RL, csf_pkg::CSF_OP_LOGIC};
		logic [7:0] a_v[7] = '{8'h0f, 8'hff, 8'h05, 8'h00, 8'h01, 8'h7f, 8'h00};
		logic [7:0] b_v[7] = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h00, 8'h00, 8'h00};
		logic [7:0] res[7] = '{8'h10, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00};
		logic [2:0] flg[7] = '{3'h2, 3'h7, 3'h7, 3'h0, 3'h1, 3'h0, 3'h4};
		for (int i = 0; i < 7; i++) begin
			@(posedge clk);
			alu_op <= ops[i];
			alu_a <= a_v[i];
			alu_b <= b_v[i];
			@(posedge clk);
			alu_op <= csf_pkg::CSF_OP_NONE;
			#1;
			check(status_out[2:0], flg[i]);
			check(alu_result, res[i]);
		end
	endtask
	// add targeting status: computed flags win, bits 4 and 3 ignore the data
	task automatic t_dest();
		@(posedge clk);
		alu_op <= csf_pkg::CSF_OP_ADD;
		alu_a <= 8'h0f;
		alu_b <= 8'h01;
		{core_wr, dest_is_status, core_wr_data} <= {2'h3, 8'h07};
		@(posedge clk);
		alu_op <= csf_pkg::CSF_OP_NONE;
		{core_wr, dest_is_status} <= 2'h0;
		#1;
		check(status_out, 8'h1a);
	endtask
	// sleep event with the interrupt masked, enabled, cleared; then kick with timeout, and status readback
	task automatic t_events();
		@(posedge clk);
		sleep_instr <= 1'h1;
		@(posedge clk);
		sleep_instr <= 1'h0;
		#1;
		check(status_out[4:3], 2'h2);
		check(irq, 1'h0);
		sw_write(csf_pkg::OFF_IRQ_EN, 8'h02);
		check(irq, 1'h1);
		sw_write(csf_pkg::OFF_IRQ_CLR, 8'h02);
		check(irq, 1'h0);
		@(posedge clk);
		watchdog_kick_instr <= 1'h1;
		watchdog_timeout <= 1'h1;
		@(posedge clk);
		watchdog_kick_instr <= 1'h0;
		watchdog_timeout <= 1'h0;
		#1;
		check(status_out[4:3], 2'h3);
		repeat (4) @(posedge clk);
		#1;
		check(status_out[4], 1'h0);
		sw_read(csf_pkg::OFF_IRQ_STAT);
		check(rd, 8'h05);
		sw_read(4'hf);
		check(rd, 8'h00);
	endtask
	task automatic wrap_up();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'h0;
		t_reset();
		t_banks();
		t_alu();
		t_dest();
		t_events();
		// mid-run reset must bring the expiry flag back from its cleared state
		@(posedge clk);
		sys_rst <= 1'h1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		t_reset();
		wrap_up();
	end
endmodule
